// ---- src/debug_ack_pulse.v ----
// Debug entry acknowledge pulse timer
`timescale 1ns/10ps
`include "row_mux_consts.vh"
module debug_ack_pulse (
   input wire sys_clk,
   input wire rstn,
   input wire debugEntry,
   output reg ackActive_q
);
   reg [`ACK_CNT_W-1:0] cnt_q;
   reg [`ACK_CNT_W-1:0] cnt_d;
   always @* begin
      cnt_d = cnt_q;
      if (debugEntry && cnt_q == `ACK_ZERO) begin
         cnt_d = `ACK_CYCLES; // [RQ10]
      end else if (cnt_q != `ACK_ZERO) begin
         cnt_d = cnt_q - `ACK_ONE;
      end
   end
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= `ACK_ZERO;
         ackActive_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         ackActive_q <= (cnt_d != `ACK_ZERO); // [RQ10]
      end
   end
endmodule // debug_ack_pulse

// ---- src/keypad_row_pin_function_mux.v ----
// Keypad row pin function multiplexer for two row pins
// Operation
// [RQ1] Select high routes debug event and test clock onto the row pins.
// [RQ2] Select low: each row pin may sense a keypad row.
// [RQ3] Audio frame sync alt feeds transmitter and receiver in synchronous mode.
// [RQ4] Audio frame sync alt feeds only the transmitter in asynchronous mode.
// [RQ5] Audio bit clock alt: both sides synchronous, transmitter only asynchronous.
// [RQ6] Alternate audio use disables the primary audio pin.
// [RQ7] General purpose outputs carry carrier detect and phone bell lines.
// [RQ8] After reset each row pin is a general purpose input.
// [RQ9] External converter drives debug event low to request debug mode.
// [RQ10] Debug entry drives debug event open drain low for three cycles.
// [RQ11] Alternate debug or test clock disconnects the primary pins.
// [RQ12] Alternate selection uses second row pin as the test clock.
// [RQ13] Pull resistors disconnect whenever a row pin is an output.
// [RQ14] Select change reroutes pins combinationally in the datapath.
`timescale 1ns/10ps
`include "row_mux_consts.vh"
module keypad_row_pin_function_mux (
   input wire sys_clk,
   input wire rstn,
   input wire pin_function_select,
   input wire fnWrite,
   input wire [`FN_W-1:0] fnA,
   input wire [`FN_W-1:0] fnB,
   input wire audioSyncMode,
   input wire carrierDetectOut,
   input wire phoneBellOut,
   input wire debugEntry,
   input wire pinAIn,
   input wire pinBIn,
   input wire primaryFrameSyncIn,
   input wire primaryBitClockIn,
   input wire primaryDebugEventIn,
   input wire primaryTestClockIn,
   input wire audioFsOut,
   input wire audioFsOutEn,
   input wire audioClkOut,
   input wire audioClkOutEn,
   output reg pinAOut_q,
   output reg pinAOe_q,
   output reg pinBOut_q,
   output reg pinBOe_q,
   output reg pinAPullEn_q,
   output reg pinBPullEn_q,
   output reg keypad_sense_line_a_q,
   output reg keypad_sense_line_b_q,
   output reg txFrameSync_q,
   output reg rxFrameSync_q,
   output reg txBitClock_q,
   output reg rxBitClock_q,
   output reg primaryFrameSyncEn_q,
   output reg primaryBitClockEn_q,
   output reg debugRequestN_q,
   output reg testClock_q,
   output reg primaryDebugEn_q,
   output reg primaryTestClockEn_q,
   output reg [`FN_W-1:0] fnAState_q,
   output reg [`FN_W-1:0] fnBState_q
);
   reg [`FN_W-1:0] fnA_q;
   reg [`FN_W-1:0] fnB_q;
   wire ackActive_q;
   reg aOut_d, aOe_d, bOut_d, bOe_d;
   reg senseA_d, senseB_d, txFs_d, rxFs_d, txCk_d, rxCk_d;
   reg dbgReqN_d, tck_d;
   reg audioA, audioB;

   // Function decode shared by both pins
   function isOutFn;
      input [`FN_W-1:0] fn;
      begin
         isOutFn = (fn == `FN_GPIO_OUT);
      end
   endfunction

   function isAudioFn;
      input [`FN_W-1:0] fn;
      begin
         isAudioFn = (fn == `FN_AUDIO_ALT);
      end
   endfunction

   debug_ack_pulse ackTimer (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .debugEntry(debugEntry),
      .ackActive_q(ackActive_q)
   );

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         fnA_q <= `FN_RESET; // [RQ8]
         fnB_q <= `FN_RESET; // [RQ8]
      end else if (fnWrite) begin
         fnA_q <= fnA;
         fnB_q <= fnB;
      end
   end

   // Routing is combinational in select; only the output register adds latency
   always @* begin
      audioA = !pin_function_select && isAudioFn(fnA_q);
      audioB = !pin_function_select && isAudioFn(fnB_q);
      aOut_d = 1'b0;
      aOe_d = 1'b0;
      bOut_d = 1'b0;
      bOe_d = 1'b0;
      senseA_d = 1'b1;
      senseB_d = 1'b1;
      txFs_d = primaryFrameSyncIn;
      rxFs_d = primaryFrameSyncIn;
      txCk_d = primaryBitClockIn;
      rxCk_d = primaryBitClockIn;
      dbgReqN_d = primaryDebugEventIn;
      tck_d = primaryTestClockIn;
      if (pin_function_select) begin // [RQ14]
         // Open drain: only ever drives low
         aOut_d = 1'b0;
         aOe_d = ackActive_q; // [RQ10]
         dbgReqN_d = pinAIn; // [RQ1] [RQ9] [RQ11]
         tck_d = pinBIn; // [RQ1] [RQ12] [RQ11]
      end else begin
         if (fnA_q == `FN_ROW_SENSE) begin
            senseA_d = pinAIn; // [RQ2]
         end
         if (fnB_q == `FN_ROW_SENSE) begin
            senseB_d = pinBIn; // [RQ2]
         end
         if (isOutFn(fnA_q)) begin
            aOut_d = carrierDetectOut; // [RQ7]
            aOe_d = 1'b1;
         end
         if (isOutFn(fnB_q)) begin
            bOut_d = phoneBellOut; // [RQ7]
            bOe_d = 1'b1;
         end
         if (audioA) begin
            aOut_d = audioFsOut;
            aOe_d = audioFsOutEn;
            txFs_d = audioFsOutEn ? audioFsOut : pinAIn; // [RQ3] [RQ4] [RQ6]
            if (audioSyncMode) begin
               rxFs_d = txFs_d; // [RQ3]
            end
         end
         if (audioB) begin
            bOut_d = audioClkOut;
            bOe_d = audioClkOutEn;
            txCk_d = audioClkOutEn ? audioClkOut : pinBIn; // [RQ5] [RQ6]
            if (audioSyncMode) begin
               rxCk_d = txCk_d; // [RQ5]
            end
         end
      end
   end

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pinAOut_q <= 1'b0;
         pinAOe_q <= 1'b0;
         pinBOut_q <= 1'b0;
         pinBOe_q <= 1'b0;
         pinAPullEn_q <= 1'b1;
         pinBPullEn_q <= 1'b1;
         keypad_sense_line_a_q <= 1'b1;
         keypad_sense_line_b_q <= 1'b1;
         txFrameSync_q <= 1'b0;
         rxFrameSync_q <= 1'b0;
         txBitClock_q <= 1'b0;
         rxBitClock_q <= 1'b0;
         primaryFrameSyncEn_q <= 1'b1;
         primaryBitClockEn_q <= 1'b1;
         debugRequestN_q <= 1'b1;
         testClock_q <= 1'b0;
         primaryDebugEn_q <= 1'b1;
         primaryTestClockEn_q <= 1'b1;
         fnAState_q <= `FN_RESET;
         fnBState_q <= `FN_RESET;
      end else begin
         pinAOut_q <= aOut_d;
         pinAOe_q <= aOe_d;
         pinBOut_q <= bOut_d;
         pinBOe_q <= bOe_d;
         pinAPullEn_q <= !aOe_d; // [RQ13]
         pinBPullEn_q <= !bOe_d; // [RQ13]
         keypad_sense_line_a_q <= senseA_d;
         keypad_sense_line_b_q <= senseB_d;
         txFrameSync_q <= txFs_d;
         rxFrameSync_q <= rxFs_d;
         txBitClock_q <= txCk_d;
         rxBitClock_q <= rxCk_d;
         primaryFrameSyncEn_q <= !audioA; // [RQ6]
         primaryBitClockEn_q <= !audioB; // [RQ6]
         debugRequestN_q <= dbgReqN_d;
         testClock_q <= tck_d;
         primaryDebugEn_q <= !pin_function_select; // [RQ11]
         primaryTestClockEn_q <= !pin_function_select; // [RQ11]
         fnAState_q <= fnA_q;
         fnBState_q <= fnB_q;
      end
   end
endmodule // keypad_row_pin_function_mux

// ---- src/row_mux_consts.vh ----
// Constants for the keypad row pin function multiplexer
`ifndef ROW_MUX_CONSTS_VH
`define ROW_MUX_CONSTS_VH
`define FN_W 2
`define FN_ROW_SENSE 2'h0
`define FN_AUDIO_ALT 2'h1
`define FN_GPIO_OUT 2'h2
`define FN_GPIO_IN 2'h3
`define FN_RESET `FN_GPIO_IN
`define ACK_CYCLES 2'h3
`define ACK_CNT_W 2
`define ACK_ZERO 2'h0
`define ACK_ONE 2'h1
`endif

// ---- test/keypad_row_pin_function_mux_assertions.sv ----
// Checker for the keypad row pin multiplexer
`timescale 1ns/10ps
`include "row_mux_consts.vh"
module row_mux_checker (
   input wire sys_clk,
   input wire rstn,
   input wire pin_function_select,
   input wire carrierDetectOut,
   input wire pinAIn,
   input wire pinBIn,
   input wire pinAOut_q,
   input wire pinAOe_q,
   input wire pinAPullEn_q,
   input wire keypad_sense_line_a_q,
   input wire testClock_q,
   input wire primaryDebugEn_q,
   input wire primaryFrameSyncEn_q,
   input wire [`FN_W-1:0] fnAState_q
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // Function state lags the live function by one edge, so it lines up with the outputs
   wire senseFnA = fnAState_q == `FN_ROW_SENSE;
   wire gpoFnA = fnAState_q == `FN_GPIO_OUT;
   wire audFnA = fnAState_q == `FN_AUDIO_ALT;
   pull_off_a: assert property (pinAPullEn_q == !pinAOe_q)
      else $error("pull on while driving");
   sense_route_a: assert property (!$past(pin_function_select) && senseFnA |->
      keypad_sense_line_a_q == $past(pinAIn)) else $error("row sense");
   gpo_drive_a: assert property (!$past(pin_function_select) && gpoFnA |->
      pinAOe_q && pinAOut_q == $past(carrierDetectOut)) else $error("gpio out");
   test_clock_a: assert property ($past(pin_function_select) |-> testClock_q == $past(pinBIn))
      else $error("test clock");
   debug_primary_a: assert property (pin_function_select |=> !primaryDebugEn_q)
      else $error("primary debug on");
   ack_length_a: assert property ($rose(pinAOe_q) && $past(pin_function_select) |->
      pinAOe_q[*3] ##1 !pinAOe_q) else $error("ack length");
   ack_low_a: assert property (pinAOe_q && $past(pin_function_select) |-> !pinAOut_q)
      else $error("ack level");
   audio_primary_a: assert property (!$past(pin_function_select) && audFnA |->
      !primaryFrameSyncEn_q) else $error("primary sync on");
   reset_gpi_a: assert property ($rose(rstn) |-> fnAState_q == `FN_GPIO_IN && !pinAOe_q)
      else $error("reset state");
   cover property ($rose(pinAOe_q) && pin_function_select);
   cover property (!$past(pin_function_select) && senseFnA && !pinAIn);
   cover property (!$past(pin_function_select) && audFnA);
endmodule // row_mux_checker
bind keypad_row_pin_function_mux row_mux_checker u_chk (.*);

// ---- test/keypad_row_pin_function_mux_test.sv ----
// Testbench for the keypad row pin function multiplexer
`timescale 1ns/10ps
`include "row_mux_consts.vh"
module keypad_row_pin_function_mux_test;
   reg sys_clk = 1'b0;
   reg rstn = 1'b0;
   reg sel = 1'b0;
   reg fnWrite = 1'b0;
   reg [`FN_W-1:0] fnA = 2'h0, fnB = 2'h0;
   reg cd = 1'b0, pb = 1'b0, dbg = 1'b0, levelA = 1'b1, levelB = 1'b1;
   reg [8:0] misc = 9'h000;
   wire pinAIn, pinBIn, aOut, aOe, bOut, bOe, senseA, senseB, tck, dbgEn;
   wire [7:0] obs = {aOe, aOut, bOe, bOut, senseA, senseB, tck, dbgEn};
   logic [15:0] notes[$];
   logic [15:0] note;
   integer fail_count = 0, checks_done = 0;
   always #5 sys_clk = ~sys_clk;
   // Side inputs stay random so no input is left tied
   always @(negedge sys_clk) misc <= 9'($urandom);
   keypad_row_pin_function_mux u_dut (
      .sys_clk(sys_clk), .rstn(rstn), .pin_function_select(sel), .fnWrite(fnWrite),
      .fnA(fnA), .fnB(fnB), .audioSyncMode(misc[0]), .carrierDetectOut(cd),
      .phoneBellOut(pb), .debugEntry(dbg), .pinAIn(pinAIn), .pinBIn(pinBIn),
      .primaryFrameSyncIn(misc[1]), .primaryBitClockIn(misc[2]),
      .primaryDebugEventIn(misc[3]), .primaryTestClockIn(misc[4]), .audioFsOut(misc[5]),
      .audioFsOutEn(misc[6]), .audioClkOut(misc[7]), .audioClkOutEn(misc[8]),
      .pinAOut_q(aOut), .pinAOe_q(aOe), .pinBOut_q(bOut), .pinBOe_q(bOe),
      .pinAPullEn_q(), .pinBPullEn_q(), .keypad_sense_line_a_q(senseA),
      .keypad_sense_line_b_q(senseB), .txFrameSync_q(), .rxFrameSync_q(),
      .txBitClock_q(), .rxBitClock_q(), .primaryFrameSyncEn_q(), .primaryBitClockEn_q(),
      .debugRequestN_q(), .testClock_q(tck), .primaryDebugEn_q(dbgEn),
      .primaryTestClockEn_q(), .fnAState_q(), .fnBState_q());
   row_far_side u_far (.pinAOut(aOut), .pinAOe(aOe), .pinBOut(bOut), .pinBOe(bOe),
      .levelA(levelA), .levelB(levelB), .pinA(pinAIn), .pinB(pinBIn));
   task final_report();
      if (fail_count == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // One note per cycle; outputs answer one edge later
   task cyc(input logic [7:0] exp, input logic [7:0] mask);
      notes.push_back({exp, mask});
      @(negedge sys_clk);
   endtask
   task setfn(input logic [1:0] a, input logic [1:0] b);
      fnA = a;
      fnB = b;
      fnWrite = 1'b1;
      @(negedge sys_clk);
      fnWrite = 1'b0;
      @(negedge sys_clk);
   endtask
   always @(posedge sys_clk) begin
      #1;
      if (notes.size() > 0) begin
         note = notes.pop_front();
         checks_done++;
         if ((obs & note[7:0]) !== note[15:8]) begin
            fail_count++;
            $display("[ERR] %0t outputs %h expected %h", $time, obs, note[15:8]);
         end
      end
   end
   initial begin
      #20000;
      fail_count++;
      final_report();
   end
   initial begin
      void'($urandom(32'h177d_5c7d));
      repeat (6) @(negedge sys_clk);
      rstn = 1'b1;
      cyc(8'h0d, 8'had);
      setfn(`FN_ROW_SENSE, `FN_ROW_SENSE);
      repeat (8) begin
         {levelA, levelB} = 2'($urandom);
         cyc({4'h0, levelA, levelB, 2'h1}, 8'had);
      end
      setfn(`FN_AUDIO_ALT, `FN_AUDIO_ALT);
      repeat (4) cyc(8'h01, 8'h01);
      setfn(`FN_GPIO_OUT, `FN_GPIO_OUT);
      repeat (8) begin
         {cd, pb} = 2'($urandom);
         cyc({1'b1, cd, 1'b1, pb, 4'hd}, 8'hfd);
      end
      sel = 1'b1;
      // Pin B still drives the old output until the next edge
      @(negedge sys_clk);
      repeat (8) begin
         levelB = 1'($urandom);
         cyc({6'h00, levelB, 1'b0}, 8'ha3);
      end
      // Entry held a second cycle: the repeat must not stretch the pulse
      for (int i = 0; i < 4; i++) begin
         dbg = (i < 2);
         cyc((i > 0) ? 8'h80 : 8'h00, 8'hc0);
      end
      cyc(8'h00, 8'hc0);
      final_report();
   end
endmodule // keypad_row_pin_function_mux_test

// ---- test/row_far_side.sv ----
// Far side model: keypad rows, debug host and test clock source
`timescale 1ns/10ps
module row_far_side (
   input wire pinAOut,
   input wire pinAOe,
   input wire pinBOut,
   input wire pinBOe,
   input wire levelA,
   input wire levelB,
   output wire pinA,
   output wire pinB
);
   // Undriven rows settle at the level the far party or its pull-up holds
   assign pinA = pinAOe ? pinAOut : levelA;
   assign pinB = pinBOe ? pinBOut : levelB;
endmodule // row_far_side
